//--- adc_core_model.sv
// ----
// Analog sample-and-convert core stand-in
// ----
module adc_core_model (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic power_i,
    input wire logic sample_i,
    input wire logic [11:0] level_i,
    output logic [11:0] result_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] held_q;
    // Track while sampling, hold through the conversion phase
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) held_q <= 12'h000;
        else if (power_i && sample_i) held_q <= level_i;
    // An unpowered core gives no valid code, so show garbage, not the last value
    assign result_o = power_i ? held_q : ~held_q;
endmodule : adc_core_model

//--- adc_seq_chk.sv
// ----
// Sequencer port checks
// ----
module adc_seq_chk
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_bit_i,
    input wire logic converter_power_enable_i,
    input wire logic result_format_select_i,
    input wire logic [3:0] input_signal_select_i,
    input wire logic [2:0] conv_clock_divider_select_i,
    input wire logic [1:0] reference_source_select_i,
    input wire logic global_irq_enable_i,
    input wire logic converter_irq_enable_i,
    input wire logic [RESULT_W-1:0] core_result_i,
    input wire logic pin_function_select_hi_i,
    input wire logic pin_function_select_lo_i,
    input wire logic pin_analog_code_i,
    input wire logic conv_busy_flag_o,
    input wire logic converter_irq_request_o,
    input wire logic irq_to_vector_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o,
    input wire logic [2:0] ref_route_o,
    input wire logic ext_path_enable_o,
    input wire logic pin_analog_mode_o,
    input wire logic pin_other_func_disable_o,
    input wire logic pin_direction_override_o,
    input wire logic pin_pullhigh_disconnect_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] cnt_q, lim_q, res_q;
    logic fmt_q, live_q;
    // Busy cycles so far, and the length owed by the divider held at start
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) cnt_q <= 12'h000;
        else cnt_q <= conv_busy_flag_o ? cnt_q + 12'h001 : 12'h000;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) lim_q <= 12'h000;
        else if (!conv_busy_flag_o) lim_q <= 12'h010 << conv_clock_divider_select_i;
    // Inputs one edge back; live_q masks the first edge after reset
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
        if (sys_rst_i) {live_q, fmt_q, res_q} <= 14'h0000;
        else {live_q, fmt_q, res_q} <= {1'b1, result_format_select_i, core_result_i};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_pulse;
        !start_bit_i ##1 start_bit_i ##1 !start_bit_i;
    endsequence
    property p_go;
        s_pulse ##0 (converter_power_enable_i && !conv_busy_flag_o) |=> conv_busy_flag_o;
    endproperty
    a_go: assert property (p_go) else $error("busy missed start");
    property p_off;
        s_pulse ##0 (!converter_power_enable_i && !conv_busy_flag_o) |=> !conv_busy_flag_o;
    endproperty
    a_off: assert property (p_off) else $error("start taken while off");
    property p_done;
        $fell(conv_busy_flag_o) |-> cnt_q == lim_q && converter_irq_request_o;
    endproperty
    a_done: assert property (p_done) else $error("bad end of conversion");
    // The vector request rises with the request, gated by the enables one edge back
    property p_vec;
        irq_to_vector_o == (converter_irq_request_o
            && $past(global_irq_enable_i && converter_irq_enable_i));
    endproperty
    a_vec: assert property (p_vec) else $error("vector request wrong");
    property p_res;
        $fell(conv_busy_flag_o) |-> {result_high_byte_o, result_low_byte_o}
            == (fmt_q ? {4'h0, res_q} : {res_q, 4'h0});
    endproperty
    a_res: assert property (p_res) else $error("result bytes wrong");
    property p_ref;
        live_q && $stable(reference_source_select_i) |-> ref_route_o ==
            (reference_source_select_i[1] ? REF_SEL_AMP
            : reference_source_select_i[0] ? REF_SEL_PIN : REF_SEL_SUPPLY);
    endproperty
    a_ref: assert property (p_ref) else $error("reference route wrong");
    property p_int;
        live_q && $stable(input_signal_select_i) && input_signal_select_i
            inside {[4'h1:4'h3], [4'h5:4'hB]} |-> !ext_path_enable_o;
    endproperty
    a_int: assert property (p_int) else $error("external path left on");
    // All four pin controls follow the function select, not just each other
    property p_pin;
        live_q && $stable({pin_function_select_hi_i, pin_function_select_lo_i, pin_analog_code_i})
            |-> {pin_analog_mode_o, pin_other_func_disable_o, pin_direction_override_o,
            pin_pullhigh_disconnect_o} == {4{!pin_function_select_hi_i
            && pin_function_select_lo_i == pin_analog_code_i}};
    endproperty
    a_pin: assert property (p_pin) else $error("analog pin not isolated");
endmodule : adc_seq_chk
bind adc_sequencer_control adc_seq_chk chk_u (.*);

//--- adc_seq_pkg.sv
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Field widths and encodings
    // ------------------------------------------------------------
    localparam int RESULT_W = 12;
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_EXT_PIN = 2'h1;
    localparam logic [3:0] INS_SUPPLY = 4'h1;
    localparam logic [3:0] INS_SUPPLY_HALF = 4'h2;
    localparam logic [3:0] INS_SUPPLY_QUARTER = 4'h3;
    localparam logic [3:0] INS_AMP = 4'h5;
    localparam logic [3:0] INS_AMP_HALF = 4'h6;
    localparam logic [3:0] INS_AMP_QUARTER = 4'h7;
    localparam logic [3:0] CHAN_LAST = 4'hB;
    localparam logic [3:0] CHAN_HOLE = 4'h9;

    // One-hot reference codes and binary internal-signal codes on the analog mux controls
    localparam logic [2:0] REF_SEL_SUPPLY = 3'h1;
    localparam logic [2:0] REF_SEL_PIN = 3'h2;
    localparam logic [2:0] REF_SEL_AMP = 3'h4;
    localparam logic [2:0] INT_NONE = 3'h0;
    localparam logic [2:0] INT_SUPPLY = 3'h1;
    localparam logic [2:0] INT_SUPPLY_HALF = 3'h2;
    localparam logic [2:0] INT_SUPPLY_QUARTER = 3'h3;
    localparam logic [2:0] INT_AMP = 3'h4;
    localparam logic [2:0] INT_AMP_HALF = 3'h5;
    localparam logic [2:0] INT_AMP_QUARTER = 3'h6;
    localparam logic [2:0] INT_GROUND = 3'h7;

    // ------------------------------------------------------------
    // Timing in conversion-clock periods; DIV_MAX is the divider count in system clocks
    // ------------------------------------------------------------
    localparam logic [4:0] SAMPLE_PERIODS = 5'h04;
    localparam logic [4:0] TOTAL_PERIODS = 5'h10;
    localparam logic [6:0] DIV_MAX = 7'h7F;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

endpackage : adc_seq_pkg

//--- adc_sequencer_control.sv
// Function
// - Reference code 00 selects supply, 01 external pin, 10/11 amplifier output.
// - Analog pin function disables other functions and overrides port direction.
// - Pull-high resistor disconnects whenever pin is an analog input.
// - Input codes 0000, 0100, 1100-1111 use external channel chosen by channel field.
// - Other input codes connect internal signal and force external path off.
// - Internal codes map to supply, fractions, amplifier, fractions, or ground.
// - Channel codes 0-8,10,11 connect pins; 1100-1111 leave input floating.
// - Start bit low-high-low starts one conversion cycle.
// - Busy flag sets when conversion initiated, stays set while converting.
// - Completion clears busy and sets the interrupt request flag.
// - Interrupt toward vector raised only when both enables are high.
// - Conversion clock is system clock divided by two to the divider code.
// - Enable powers converter; software waits start-up delay before starting.
// - Conversion is 4 sampling periods then 12 conversion periods, 16 total.
// - Format 0: high 11..4, low 3..0; format 1: high 11..8, low 7..0.
// - Clearing enable leaves result registers unchanged; a conversion in progress still completes and loads them.
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_bit_i,
    input wire logic converter_power_enable_i,
    input wire logic result_format_select_i,
    input wire logic [3:0] external_channel_select_i,
    input wire logic [3:0] input_signal_select_i,
    input wire logic [2:0] conv_clock_divider_select_i,
    input wire logic [1:0] reference_source_select_i,
    input wire logic global_irq_enable_i,
    input wire logic converter_irq_enable_i,
    input wire logic irq_request_clear_i,
    input wire logic pin_function_select_hi_i,
    input wire logic pin_function_select_lo_i,
    input wire logic pin_analog_code_i,
    input wire logic [RESULT_W-1:0] core_result_i,
    output logic conv_busy_flag_o,
    output logic converter_irq_request_o,
    output logic irq_to_vector_o,
    output logic [7:0] result_high_byte_o,
    output logic [7:0] result_low_byte_o,
    output logic [2:0] ref_route_o,
    output logic ext_path_enable_o,
    output logic [3:0] ext_channel_o,
    output logic [2:0] internal_signal_o,
    output logic core_power_o,
    output logic core_sample_o,
    output logic conv_clock_tick_o,
    output logic pin_analog_mode_o,
    output logic pin_other_func_disable_o,
    output logic pin_direction_override_o,
    output logic pin_pullhigh_disconnect_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_external(input logic [3:0] code);
        is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'h3);
    endfunction : is_external

    function automatic logic [2:0] internal_of(input logic [3:0] code);
        logic [2:0] r;
        r = INT_NONE;
        case (code)
            INS_SUPPLY: r = INT_SUPPLY;
            INS_SUPPLY_HALF: r = INT_SUPPLY_HALF;
            INS_SUPPLY_QUARTER: r = INT_SUPPLY_QUARTER;
            INS_AMP: r = INT_AMP;
            INS_AMP_HALF: r = INT_AMP_HALF;
            INS_AMP_QUARTER: r = INT_AMP_QUARTER;
            default: r = (code[3:2] == 2'h2) ? INT_GROUND : INT_NONE;
        endcase
        internal_of = r;
    endfunction : internal_of

    logic start_prev_q;
    logic busy_q;
    logic irq_req_q;
    logic irq_vec_q;
    conv_state_t state_q;
    logic [6:0] div_cnt_q;
    logic [4:0] period_cnt_q;
    logic tick_q;
    logic tick_now;
    logic start_go;
    logic done_now;
    logic irq_req_d;

    // ------------------------------------------------------------
    // Start sequence detection
    // ------------------------------------------------------------
    // A fall after a sampled high fires; the history clears on reset, so a bit
    // left high never starts a second conversion until it has gone low again.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            start_prev_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= start_bit_i;
        end
    end

    assign start_go = start_prev_q && !start_bit_i
        && converter_power_enable_i;

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    // Divider restarts on each start so the first period is always whole.
    // Only an accepted start restarts it; a refused one must not stretch a run.
    assign tick_now = (div_cnt_q[6:0] & ((7'h01 << conv_clock_divider_select_i) - 7'h01))
        == ((7'h01 << conv_clock_divider_select_i) - 7'h01);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= tick_now && (state_q != ST_IDLE);
            if ((start_go && state_q == ST_IDLE) || tick_now || div_cnt_q == DIV_MAX)
            begin
                div_cnt_q <= 7'h00;
            end
            else
            begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    assign done_now = (state_q == ST_CONVERT) && tick_now && (period_cnt_q == TOTAL_PERIODS - 5'h01);

    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            period_cnt_q <= 5'h00;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_go)
                    begin
                        state_q <= ST_SAMPLE;
                        period_cnt_q <= 5'h00;
                        busy_q <= 1'b1;
                    end
                end
                ST_SAMPLE:
                begin
                    if (tick_now)
                    begin
                        period_cnt_q <= period_cnt_q + 5'h01;
                        if (period_cnt_q == SAMPLE_PERIODS - 5'h01)
                        begin
                            state_q <= ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT:
                begin
                    if (done_now)
                    begin
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                    end
                    else if (tick_now)
                    begin
                        period_cnt_q <= period_cnt_q + 5'h01;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt request and vector request
    // ------------------------------------------------------------
    // Completion wins over a software clear in the same cycle.
    assign irq_req_d = done_now || (irq_req_q && !irq_request_clear_i);

    // The vector request follows the request's next value, so both rise together
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            irq_req_q <= 1'b0;
            irq_vec_q <= 1'b0;
        end
        else
        begin
            irq_req_q <= irq_req_d;
            irq_vec_q <= irq_req_d && global_irq_enable_i
                && converter_irq_enable_i;
        end
    end

    // ------------------------------------------------------------
    // Result register pair
    // ------------------------------------------------------------
    // Loaded only at completion, so disabling the converter while idle keeps it.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            result_high_byte_o <= 8'h00;
            result_low_byte_o <= 8'h00;
        end
        else if (done_now)
        begin
            if (result_format_select_i)
            begin
                result_high_byte_o <= {4'h0, core_result_i[11:8]};
                result_low_byte_o <= core_result_i[7:0];
            end
            else
            begin
                result_high_byte_o <= core_result_i[11:4];
                result_low_byte_o <= {core_result_i[3:0], 4'h0};
            end
        end
    end

    // ------------------------------------------------------------
    // Analog routing and pin control
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ref_route_o <= REF_SEL_SUPPLY;
            ext_path_enable_o <= 1'b0;
            ext_channel_o <= 4'h0;
            internal_signal_o <= INT_NONE;
            core_power_o <= 1'b0;
            core_sample_o <= 1'b0;
            pin_analog_mode_o <= 1'b0;
            pin_other_func_disable_o <= 1'b0;
            pin_direction_override_o <= 1'b0;
            pin_pullhigh_disconnect_o <= 1'b0;
        end
        else
        begin
            case (reference_source_select_i)
                REF_SUPPLY: ref_route_o <= REF_SEL_SUPPLY;
                REF_EXT_PIN: ref_route_o <= REF_SEL_PIN;
                default: ref_route_o <= REF_SEL_AMP;
            endcase
            // Reserved and out-of-range channel codes leave the input floating
            ext_path_enable_o <= is_external(input_signal_select_i)
                && (external_channel_select_i <= CHAN_LAST)
                && (external_channel_select_i != CHAN_HOLE);
            ext_channel_o <= external_channel_select_i;
            internal_signal_o <= internal_of(input_signal_select_i);
            core_power_o <= converter_power_enable_i;
            core_sample_o <= (state_q == ST_SAMPLE);
            pin_analog_mode_o <= {pin_function_select_hi_i, pin_function_select_lo_i}
                == {1'b0, pin_analog_code_i};
            pin_other_func_disable_o <= {pin_function_select_hi_i, pin_function_select_lo_i}
                == {1'b0, pin_analog_code_i};
            pin_direction_override_o <= {pin_function_select_hi_i, pin_function_select_lo_i}
                == {1'b0, pin_analog_code_i};
            pin_pullhigh_disconnect_o <= {pin_function_select_hi_i, pin_function_select_lo_i}
                == {1'b0, pin_analog_code_i};
        end
    end

    assign conv_busy_flag_o = busy_q;
    assign converter_irq_request_o = irq_req_q;
    assign irq_to_vector_o = irq_vec_q;
    assign conv_clock_tick_o = tick_q;

endmodule : adc_sequencer_control

//--- adc_sequencer_control_tb_top.sv
module adc_sequencer_control_tb_top import adc_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Stimulus, notes and watch
    // ----
    logic sys_clk_i, sys_rst_i, start_bit_i, converter_power_enable_i, result_format_select_i;
    logic global_irq_enable_i, converter_irq_enable_i, irq_request_clear_i, pin_analog_code_i;
    logic pin_function_select_hi_i, pin_function_select_lo_i, conv_busy_flag_o, irq_to_vector_o;
    logic converter_irq_request_o, ext_path_enable_o, core_power_o, core_sample_o, busy_prev;
    logic conv_clock_tick_o, pin_analog_mode_o, pin_other_func_disable_o;
    logic pin_direction_override_o, pin_pullhigh_disconnect_o;
    logic [3:0] external_channel_select_i, input_signal_select_i, ext_channel_o;
    logic [2:0] conv_clock_divider_select_i, ref_route_o, internal_signal_o;
    logic [1:0] reference_source_select_i;
    logic [RESULT_W-1:0] core_result_i, level;
    logic [7:0] result_high_byte_o, result_low_byte_o;
    logic [15:0] exp_q[$];
    logic [15:0] last;
    logic [31:0] rng;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int ticks = 0;
    logic [15:0] got;
    // Internal signal code per input code, entry 0 at the bottom
    localparam logic [47:0] ISIG_TAB = 48'h000FFFD60688;
    adc_sequencer_control dut_u (.*);
    adc_core_model core_u (.sys_clk_i, .sys_rst_i, .power_i(core_power_o),
        .sample_i(core_sample_o), .level_i(level), .result_o(core_result_i));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic pulse;
        start_bit_i = 1'b1;
        step(1);
        start_bit_i = 1'b0;
        step(1);
    endtask : pulse
    // One conversion: note the result, time busy, then follow up the request
    task automatic conv(input logic [2:0] d, input logic f, input logic g, input logic c);
        int n;
        conv_clock_divider_select_i = d;
        result_format_select_i = f;
        global_irq_enable_i = g;
        converter_irq_enable_i = c;
        rng = xs(rng);
        level = rng[11:0];
        step(2);
        last = f ? {4'h0, level} : {level, 4'h0};
        exp_q.push_back(last);
        pulse();
        chk("busy_on", 16'h0001, {15'h0, conv_busy_flag_o});
        for (n = 0; conv_busy_flag_o === 1'b1 && n < 4096; n++) step(1);
        chk("conv_len", 16'h0010 << d, n[15:0]);
        chk("irq_req", 16'h0001, {15'h0, converter_irq_request_o});
        step(1);
        chk("irq_vec", {15'h0, g & c}, {15'h0, irq_to_vector_o});
        irq_request_clear_i = 1'b1;
        step(1);
        irq_request_clear_i = 1'b0;
    endtask : conv
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Hang guard, and result compare on every busy fall
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
        #2;
        // Conversion clock ticks seen during the run, checked when busy falls
        if (conv_clock_tick_o === 1'b1) ticks++;
        if (busy_prev === 1'b1 && conv_busy_flag_o === 1'b0)
        begin
            got = {result_high_byte_o, result_low_byte_o};
            if (exp_q.size() == 0) chk("result_note", 16'h0001, 16'h0000);
            else chk("result", exp_q.pop_front(), got);
            chk("ticks", {11'h000, TOTAL_PERIODS}, ticks[15:0]);
            ticks = 0;
        end
        busy_prev = conv_busy_flag_o;
    end
    initial
    begin
        rng = 32'h0000FA52;
        {sys_rst_i, start_bit_i, converter_power_enable_i, result_format_select_i} = 4'h8;
        {global_irq_enable_i, converter_irq_enable_i, irq_request_clear_i, busy_prev} = 4'h0;
        {pin_function_select_hi_i, pin_function_select_lo_i, pin_analog_code_i} = 3'h0;
        {external_channel_select_i, input_signal_select_i, level} = 20'h00000;
        {conv_clock_divider_select_i, reference_source_select_i} = 5'h00;
        repeat (16) @(posedge sys_clk_i);
        #1 sys_rst_i = 1'b0;
        // Pin function codes, with the high select bit both low and high
        for (int i = 0; i < 8; i++)
        begin
            {pin_function_select_hi_i, pin_analog_code_i, pin_function_select_lo_i} = i[2:0];
            step(2);
            chk("pin", {12'h0, {4{!i[2] && i[1] == i[0]}}}, {12'h0, pin_analog_mode_o,
                pin_other_func_disable_o, pin_direction_override_o,
                pin_pullhigh_disconnect_o});
        end
        pin_function_select_hi_i = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            {input_signal_select_i, external_channel_select_i} = {i[3:0], 4'h2};
            reference_source_select_i = i[1:0];
            step(2);
            chk("ref", {13'h0, i[1] ? REF_SEL_AMP : i[0] ? REF_SEL_PIN : REF_SEL_SUPPLY},
                {13'h0, ref_route_o});
            chk("int_sig", {13'h0, ISIG_TAB[i*3 +: 3]}, {13'h0, internal_signal_o});
            chk("ext_path", {15'h0, ISIG_TAB[i*3 +: 3] == 3'h0},
                {15'h0, ext_path_enable_o});
            {input_signal_select_i, external_channel_select_i} = {4'h0, i[3:0]};
            step(2);
            chk("chan_on", {15'h0, i < 12 && i != 9}, {15'h0, ext_path_enable_o});
            if (i < 12 && i != 9) chk("chan", i[15:0], {12'h0, ext_channel_o});
        end
        converter_power_enable_i = 1'b1;
        step(8);
        for (int k = 0; k < 8; k++) conv(k[2:0], k[2] ^ k[0], k[1], k[0]);
        // 640 ns conversion clock at 100 MHz, inside the recommended band
        conv(3'h6, 1'b0, 1'b1, 1'b1);
        converter_power_enable_i = 1'b0;
        step(2);
        pulse();
        step(20);
        chk("refused", 16'h0000, {14'h0, conv_busy_flag_o, converter_irq_request_o});
        chk("hold", last, {result_high_byte_o, result_low_byte_o});
        end_of_test();
    end
endmodule : adc_sequencer_control_tb_top
